// ---- rtl/csk_exec.sv ----
// Execution logic for the equal-skip and greater-skip compare instructions
// Notes on behaviour
// - Opcodes 0110001a and 0110010a, a bank bit.
// - Equal compare discards next instruction on match.
// - Greater compare is unsigned, skips only when greater.
// - Bank bit 0 access bank, 1 bank register.
// - Extended, bank 0, address<=95: indexed offset.
// - One cycle unskipped; two when skipping one-word.
module csk_exec
    import csk_pkg::*;
(
    input wire logic i_clock, // 10 MHz instruction clock
    input wire logic i_rstn, // Asynchronous reset, active low
    input wire logic i_instr_valid, // Fetched instruction presented
    input wire logic [15:0] i_instr, // Instruction word
    input wire logic i_next_two_word, // Next fetched op is two words
    input wire logic i_ext_enable, // Extended instruction set on
    input wire logic [CSK_BANK_W-1:0] i_bank_select_register, // Bank
    input wire logic [CSK_ADDR_W-1:0] i_index_base, // Window base
    input wire logic [7:0] i_wreg, // Working register
    input wire logic [7:0] i_mem_rdata, // Byte at o_mem_addr
    output logic o_ready, // Block accepts an instruction
    output logic o_is_compare, // Presented op is one of ours
    output logic [CSK_ADDR_W-1:0] o_mem_addr, // Operand address
    output logic o_mem_rd, // Operand read strobe
    output logic o_nop_cycle, // Current cycle is a no-operation
    output logic o_discard, // Drop the fetched instruction
    output logic o_skip_taken, // Last compare skipped
    output logic o_status_we // Status flag write, never raised
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    csk_decode_t dec; // Decoded fields
    csk_addr_ctx_t ctx; // Addressing context
    csk_state_t state_reg; // Sequence state
    csk_state_t state_next; // Next sequence state
    logic two_word_reg; // Skipped op is two words
    logic two_word_next; // Next value of two_word_reg
    logic skip_reg; // Last compare result
    logic skip_next; // Next value of skip_reg
    logic nop_reg; // No-operation cycle flag
    logic discard_reg; // Discard strobe
    logic indexed; // Indexed literal offset in use

    // Opcode match on the top seven bits
    assign dec.is_eq = (i_instr[CSK_OP_MSB:CSK_OP_LSB] == CSK_OP_EQ);
    assign dec.is_gt = (i_instr[CSK_OP_MSB:CSK_OP_LSB] == CSK_OP_GT);
    // Bank bit and register file address sit below the opcode
    assign dec.bank_sel = i_instr[CSK_BANK_BIT];
    assign dec.file_addr = i_instr[7:0];
    // Banking context travels as one struct into the resolver
    assign ctx.ext_enable = i_ext_enable;
    assign ctx.bank_select_register = i_bank_select_register;
    assign ctx.index_base = i_index_base;

    // ------------------------------------------------------------
    // Operand address
    // ------------------------------------------------------------
    // Pure logic, so the address is ready within the accept cycle
    // and the memory answers in that same cycle
    csk_addr_resolve u_addr (
        .i_dec(dec),
        .i_ctx(ctx),
        .o_addr(o_mem_addr),
        .o_indexed(indexed)
    );

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    // One of our two opcodes is on the instruction bus
    wire is_cmp = dec.is_eq || dec.is_gt;
    // Taken only while idle; busy cycles ignore the bus
    wire accept = i_instr_valid && is_cmp && (state_reg == CSK_READY);
    // Subtraction kept internal, never written back
    wire [8:0] diff = {1'b0, i_mem_rdata} - {1'b0, i_wreg};
    // Zero difference means the byte matches the working register
    wire equal = (diff == 9'h000);
    // No borrow and not equal: byte above the working register, unsigned
    wire greater = !diff[8] && !equal;
    // Skip decision for whichever compare is decoded
    wire take = (dec.is_eq && equal) || (dec.is_gt && greater);

    // Handshake outputs are combinational, result flags are registered
    assign o_ready = (state_reg == CSK_READY);
    assign o_is_compare = is_cmp;
    assign o_mem_rd = accept;
    assign o_nop_cycle = nop_reg;
    assign o_discard = discard_reg;
    assign o_skip_taken = skip_reg;
    assign o_status_we = 1'b0;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state: one cycle unless skipping, one or two NOPs after
    always_comb begin
        // Hold everything unless a branch below moves it
        state_next = state_reg;
        two_word_next = two_word_reg;
        skip_next = skip_reg;
        unique case (state_reg)
            CSK_READY: begin
                // Capture the result and the length of what follows
                if (accept) begin
                    skip_next = take;
                    two_word_next = i_next_two_word;
                    if (take) begin
                        // First discarded word becomes a no-operation
                        state_next = CSK_NOP_FIRST;
                    end
                end
            end
            CSK_NOP_FIRST: begin
                // Second discarded word costs one more NOP
                state_next = two_word_reg ? CSK_NOP_SECOND : CSK_READY;
            end
            CSK_NOP_SECOND: begin
                // Both words of the skipped op are gone
                state_next = CSK_READY;
            end
            default: begin
                // Unused code falls back to idle
                state_next = CSK_READY;
            end
        endcase
    end

    // State and flag registers
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            // Idle, no skip pending, flags clear
            state_reg <= CSK_READY;
            two_word_reg <= 1'b0;
            skip_reg <= 1'b0;
            nop_reg <= 1'b0;
            discard_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            two_word_reg <= two_word_next;
            skip_reg <= skip_next;
            // No-operation flag mirrors the state being entered
            nop_reg <= (state_next != CSK_READY);
            // Discard strobe only in the cycle after a taken skip
            discard_reg <= accept && take;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // All checks run on the instruction clock and sleep during reset
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // Equal compare: a match drops the next instruction
    eq_match_skip_a: assert property (
        accept && dec.is_eq && (i_mem_rdata == i_wreg) |=> o_discard && o_nop_cycle)
        else $error("equal match did not skip");
    // Equal compare: a miss runs straight on
    eq_miss_run_a: assert property (
        accept && dec.is_eq && (i_mem_rdata != i_wreg) |=> !o_nop_cycle && !o_discard)
        else $error("equal miss skipped");
    // Greater compare treats both bytes as unsigned
    gt_unsigned_a: assert property (
        accept && dec.is_gt |=> o_skip_taken == ($past(i_mem_rdata) > $past(i_wreg)))
        else $error("greater compare wrong");
    // Result flag holds until the next accepted compare
    skip_hold_a: assert property (
        !accept |=> $stable(o_skip_taken))
        else $error("skip flag moved without a compare");

    // Skip over a one-word op costs a single no-operation cycle
    one_word_skip_a: assert property (
        accept && take && !i_next_two_word |=> o_nop_cycle ##1 !o_nop_cycle && o_ready)
        else $error("one-word skip length");
    // Skip over a two-word op costs two no-operation cycles
    two_word_skip_a: assert property (
        accept && take && i_next_two_word |=> o_nop_cycle [*2] ##1 !o_nop_cycle && o_ready)
        else $error("two-word skip length");
    // Discard is a one-cycle strobe, even over a two-word op
    discard_pulse_a: assert property (
        o_discard |=> !o_discard)
        else $error("discard held too long");
    // Idle and no-operation cycles never overlap
    ready_nop_a: assert property (
        o_ready != o_nop_cycle)
        else $error("ready and no-operation disagree");
    // Compares never write the status flags
    no_status_a: assert property (
        accept |-> (!o_status_we) [*4])
        else $error("status written");

    // Bank bit set: bank select register supplies the upper address
    banked_addr_a: assert property (
        i_instr_valid && is_cmp && dec.bank_sel
        |-> o_mem_addr == {i_bank_select_register, dec.file_addr})
        else $error("banked address wrong");
    // Extended set, bank bit clear, low address: indexed window
    indexed_addr_a: assert property (
        i_instr_valid && is_cmp && i_ext_enable
        && !dec.bank_sel && (dec.file_addr <= CSK_INDEX_LIMIT)
        |-> o_mem_addr == CSK_ADDR_W'(i_index_base + dec.file_addr))
        else $error("indexed address wrong");
    // Plain access bank splits at the window limit
    access_addr_a: assert property (
        i_instr_valid && is_cmp && !dec.bank_sel
        && (!i_ext_enable || (dec.file_addr > CSK_INDEX_LIMIT))
        |-> o_mem_addr[7:0] == dec.file_addr && o_mem_addr[CSK_ADDR_W-1:8]
        == ((dec.file_addr > CSK_INDEX_LIMIT) ? CSK_ACCESS_HIGH_BANK : CSK_ACCESS_LOW_BANK))
        else $error("access address wrong");
    // Only the two compare opcodes are claimed
    opcode_decode_a: assert property (
        o_is_compare == ((i_instr[15:12] == 4'h6)
        && ((i_instr[11:9] == 3'h1) || (i_instr[11:9] == 3'h2))))
        else $error("opcode claim wrong");
    // A foreign opcode leaves the sequencer idle
    foreign_idle_a: assert property (
        o_ready && !o_is_compare |=> o_ready && !o_discard)
        else $error("foreign opcode started a skip");

    // Main scenarios
    eq_skip_c: cover property (accept && dec.is_eq && take);
    gt_skip_two_c: cover property (accept && dec.is_gt && take && i_next_two_word);
    gt_no_skip_c: cover property (accept && dec.is_gt && !take);
    eq_skip_two_c: cover property (accept && dec.is_eq && take && i_next_two_word);
    indexed_op_c: cover property (accept && indexed);

endmodule : csk_exec

// ---- rtl/csk_pkg.sv ----
// Shared constants and types for the compare-and-skip execution block
package csk_pkg;

    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam logic [6:0] CSK_OP_EQ = 7'h31; // 0110 001 : skip if equal
    localparam logic [6:0] CSK_OP_GT = 7'h32; // 0110 010 : skip if greater
    localparam int CSK_OP_MSB = 15; // Top of opcode field
    localparam int CSK_OP_LSB = 9; // Bottom of opcode field
    localparam int CSK_BANK_BIT = 8; // Bank access selector position

    // ------------------------------------------------------------
    // Data memory addressing
    // ------------------------------------------------------------
    localparam int CSK_ADDR_W = 14; // Data memory address width
    localparam int CSK_BANK_W = 6; // Bank select width
    localparam logic [7:0] CSK_INDEX_LIMIT = 8'h5F; // Last indexed offset
    localparam logic [5:0] CSK_ACCESS_LOW_BANK = 6'h00; // Lower access half
    localparam logic [5:0] CSK_ACCESS_HIGH_BANK = 6'h3F; // Upper access half

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int CSK_NOP_ONE_WORD = 1; // Discard cycles over 1-word op
    localparam int CSK_NOP_TWO_WORD = 2; // Discard cycles over 2-word op

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic is_eq; // Equal-skip compare
        logic is_gt; // Greater-skip compare
        logic bank_sel; // Bank access selector
        logic [7:0] file_addr; // Register file address
    } csk_decode_t;

    typedef struct packed {
        logic ext_enable; // Extended instruction set enabled
        logic [CSK_BANK_W-1:0] bank_select_register; // Current bank
        logic [CSK_ADDR_W-1:0] index_base; // Indexed window base
    } csk_addr_ctx_t;

    typedef enum logic [1:0] {
        CSK_READY,
        CSK_NOP_FIRST,
        CSK_NOP_SECOND
    } csk_state_t;

endpackage : csk_pkg

// ---- rtl/csk_addr_resolve.sv ----
// Operand address resolver for the compare-and-skip block
module csk_addr_resolve
    import csk_pkg::*;
(
    input wire csk_decode_t i_dec, // Decoded instruction fields
    input wire csk_addr_ctx_t i_ctx, // Banking context
    output logic [CSK_ADDR_W-1:0] o_addr, // Resolved data address
    output logic o_indexed // Indexed literal offset used
);

    // ------------------------------------------------------------
    // Address selection
    // ------------------------------------------------------------
    wire use_index = i_ctx.ext_enable && !i_dec.bank_sel
                     && (i_dec.file_addr <= CSK_INDEX_LIMIT);
    wire [CSK_ADDR_W-1:0] index_addr = i_ctx.index_base
                     + {{(CSK_ADDR_W-8){1'b0}}, i_dec.file_addr};
    wire [CSK_BANK_W-1:0] access_bank = (i_dec.file_addr <= CSK_INDEX_LIMIT)
                     ? CSK_ACCESS_LOW_BANK : CSK_ACCESS_HIGH_BANK;
    wire [CSK_ADDR_W-1:0] access_addr = {access_bank, i_dec.file_addr};
    wire [CSK_ADDR_W-1:0] banked_addr = {i_ctx.bank_select_register,
                                         i_dec.file_addr};

    // Bank bit 1 uses the bank select register, else access or window
    assign o_addr = i_dec.bank_sel ? banked_addr
                  : (use_index ? index_addr : access_addr);
    assign o_indexed = use_index;

endmodule : csk_addr_resolve

// ---- dv/csk_data_mem.sv ----
// Behavioural data memory feeding operand bytes to the compare block
module csk_data_mem
    import csk_pkg::*;
(
    input wire logic i_clock, // Instruction clock
    input wire logic i_mem_rd, // Read strobe
    input wire logic [CSK_ADDR_W-1:0] i_mem_addr, // Byte address
    output logic [7:0] o_rdata // Byte read back
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flip_reg = 1'b0; // Toggles so idle data never looks stable
    // Contents are a fixed scramble of the address
    function automatic logic [7:0] byte_of(input logic [CSK_ADDR_W-1:0] a);
        return a[7:0] ^ {a[13:8], 2'b01} ^ 8'hA5;
    endfunction : byte_of
    always @(posedge i_clock) flip_reg <= ~flip_reg;
    // Without a read strobe the bus shows moving garbage
    assign o_rdata = i_mem_rd ? byte_of(i_mem_addr) : ~byte_of(i_mem_addr) ^ {8{flip_reg}};
endmodule : csk_data_mem

// ---- dv/testbench.sv ----
// Self-checking bench for the compare-and-skip block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import csk_pkg::*;
    typedef struct packed {
        logic skip; // Skip expected
        logic two; // Two-word op follows
        logic [CSK_ADDR_W-1:0] addr; // Expected operand address
    } csk_note_t;
    logic i_clock = 1'b0, i_rstn, i_instr_valid, i_next_two_word, i_ext_enable;
    logic [15:0] i_instr;
    logic [CSK_BANK_W-1:0] i_bank_select_register;
    logic [CSK_ADDR_W-1:0] i_index_base, o_mem_addr;
    logic [7:0] i_wreg, mem_rdata;
    logic o_ready, o_is_compare, o_mem_rd, o_nop_cycle, o_discard, o_skip_taken, o_status_we;
    logic [31:0] lfsr_reg = 32'h5967_1f5f; // Random source state
    logic [7:0] woffs[3] = '{8'h00, 8'hFF, 8'h01}; // Equal, byte above, byte below
    int err_count = 0, n_checks = 0, stage = 0;
    csk_note_t q[$];
    csk_note_t cur;
    logic [31:0] r;

    always #50 i_clock = ~i_clock;
    csk_exec i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_next_two_word(i_next_two_word), .i_ext_enable(i_ext_enable),
        .i_bank_select_register(i_bank_select_register), .i_index_base(i_index_base),
        .i_wreg(i_wreg), .i_mem_rdata(mem_rdata), .o_ready(o_ready),
        .o_is_compare(o_is_compare), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_nop_cycle(o_nop_cycle), .o_discard(o_discard), .o_skip_taken(o_skip_taken),
        .o_status_we(o_status_we));
    csk_data_mem i_mem (.i_clock(i_clock), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
        .o_rdata(mem_rdata));

    // Step the feedback shift register
    function automatic logic [31:0] rnd();
        lfsr_reg = lfsr_reg[0] ? (lfsr_reg >> 1) ^ 32'h8020_0003 : lfsr_reg >> 1;
        return lfsr_reg;
    endfunction : rnd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    // Present one compare, note the expectation, wait out any skip
    task op(input logic gt, a, ext, input logic [7:0] f, woff, input logic two);
        csk_note_t n;
        logic [7:0] d;
        logic [CSK_BANK_W-1:0] bank;
        logic [CSK_ADDR_W-1:0] base;
        bank = CSK_BANK_W'(rnd());
        base = CSK_ADDR_W'(rnd());
        if (a) n.addr = {bank, f};
        else if (ext && f <= 8'h5F) n.addr = base + f;
        else n.addr = {(f <= 8'h5F) ? 6'h00 : 6'h3F, f};
        d = i_mem.byte_of(n.addr);
        n.skip = gt ? (d > 8'(d + woff)) : (woff == 8'h00);
        n.two = two;
        i_instr <= {gt ? CSK_OP_GT : CSK_OP_EQ, a, f};
        i_instr_valid <= 1'b1;
        i_wreg <= d + woff;
        i_next_two_word <= two;
        i_ext_enable <= ext;
        i_bank_select_register <= bank;
        i_index_base <= base;
        q.push_back(n);
        @(posedge i_clock);
        if (n.skip) begin
            i_instr_valid <= 1'b0;
            do @(negedge i_clock); while (o_ready !== 1'b1);
            @(posedge i_clock);
        end
    endtask : op

    // Result watcher, paced by the design's own accept condition
    always @(negedge i_clock) begin
        if (i_rstn) begin
            if (stage == 3) begin
                chk({o_ready, o_nop_cycle}, 2'h2);
                stage = 0;
            end else if (stage == 2) begin
                chk({o_nop_cycle, o_discard}, 2'h2);
                stage = 3;
            end else if (stage == 1) begin
                chk(o_skip_taken, cur.skip);
                chk(o_discard, cur.skip);
                chk(o_nop_cycle, cur.skip);
                stage = !cur.skip ? 0 : (cur.two ? 2 : 3);
            end
            chk(o_status_we, 0);
            if (i_instr_valid && o_is_compare && o_ready) begin
                chk(q.size() > 0, 1);
                cur = q.pop_front();
                chk(o_mem_addr, cur.addr);
                chk(o_mem_rd, 1);
                stage = 1;
            end
        end else begin
            stage = 0;
        end
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge i_clock);
        err_count++;
        end_sim();
    end

    initial begin
        {i_rstn, i_instr_valid, i_next_two_word, i_ext_enable} = 4'h0;
        {i_instr, i_bank_select_register, i_index_base, i_wreg} = '0;
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(negedge i_clock);
        chk({o_ready, o_nop_cycle, o_discard, o_skip_taken}, 4'h8);
        @(posedge i_clock);
        for (int i = 0; i < 48; i++) begin
            op(i[0], i[1], i[2], i[3] ? 8'h60 : 8'h5F, woffs[i % 3], i[4]);
        end
        $display("test boundary_sweep done");
        for (int i = 0; i < 200; i++) begin
            r = rnd();
            op(r[0], r[1], r[2], r[15:8], woffs[r[17:16] % 3], r[3]);
        end
        $display("test random_ops done");
        // A taken skip sets the result flag; a reset in mid-run must clear it
        op(1'b0, 1'b1, 1'b0, 8'h20, 8'h00, 1'b0);
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(negedge i_clock);
        chk({o_ready, o_nop_cycle, o_discard, o_skip_taken}, 4'h8);
        @(posedge i_clock);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            op(r[0], r[1], r[2], r[15:8], woffs[r[17:16] % 3], r[3]);
        end
        $display("test mid_reset done");
        i_instr <= {7'h33, 9'h0A5};
        i_instr_valid <= 1'b1;
        @(negedge i_clock);
        chk(o_is_compare, 0);
        @(posedge i_clock);
        i_instr <= {7'h30, 9'h1F0};
        @(negedge i_clock);
        chk(o_is_compare, 0);
        @(posedge i_clock);
        i_instr_valid <= 1'b0;
        repeat (3) @(posedge i_clock);
        chk(16'(q.size()), 0);
        $display("test foreign_opcodes done");
        end_sim();
    end
endmodule : testbench
